// [io_port_key_irq_alarm_gating_tb_top.sv]
// Purpose: Self-checking bench for the port, key and gating glue
// Assumes: Short restart hold-off set through the parameter
// Notes:   Random port values from a fixed xorshift seed
module io_port_key_irq_alarm_gating_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned HOLD = 12;
    logic        core_clk, rst_n, lbat_n, rx, up, bz_p, bz_n, bo_p, bo_n, u_sel_n, u_shdn_n, vcut, ir_pd;
    logic        d_sel_n, d_rst_n, loop_en, light, vibe, load, irq, akr, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  keys_n, avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, seed, rd;
    logic [7:0]  v;
    logic [4:0]  pats [7] = '{5'h1e, 5'h1d, 5'h1b, 5'h17, 5'h0f, 5'h00, 5'h1f};
    int          err_total, checked;

    iokia_glue #(.RESTART_CYCLES(HOLD)) iokia_glue_i (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .low_battery_reset_n(lbat_n), .down_button_n(keys_n[0]),
        .up_button_n(keys_n[1]), .select_button_n(keys_n[2]), .action_button_n(keys_n[3]),
        .hidden_button_n(keys_n[4]), .radio_rx_active(rx), .upconverter_on(up), .buzzer_drive_pos(bz_p),
        .buzzer_drive_neg(bz_n), .buzzer_out_pos(bo_p), .buzzer_out_neg(bo_n), .uart_select_n(u_sel_n),
        .uart_shutdown_n(u_shdn_n), .vcc_cut(vcut), .infrared_power_down(ir_pd), .display_select_n(d_sel_n),
        .display_reset_n(d_rst_n), .display_clock_loopback_en(loop_en), .backlight_en(light),
        .vibe_motor_en(vibe), .test_load_en(load), .keypad_irq(irq), .all_keys_reset(akr));
    iokia_host_model iokia_host_model_i (.core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .keypad_irq(irq), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic sup(input logic [7:0] p, input logic r);
        return p[4] & ~p[7] & r;
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        err_total += iokia_host_model_i.to_cnt;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        iokia_host_model_i.access(1'b1, a, d, rd);
    endtask
    task automatic rdchk(input string name, input logic [4:0] a, input logic [31:0] exp);
        iokia_host_model_i.access(1'b0, a, 8'h00, rd);
        chk(name, exp, rd);
    endtask
    task automatic pins(input logic [7:0] p, input logic s);
        chk("sel_n", p[0], d_sel_n);
        chk("rst_n", p[1], d_rst_n);
        chk("loop", p[2], loop_en);
        chk("light", p[5] & ~s, light);
        chk("vibe", p[6] & ~s, vibe);
        chk("load", p[7], load);
    endtask
    task automatic waitn(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    initial begin
        {rst_n, rx, bz_p, bz_n} = 4'h0;
        {lbat_n, up} = 2'b11;
        keys_n = 5'h1f;
        seed = 32'h6d70;
        err_total = 0;
        checked = 0;
        waitn(2);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk("ir_pd", 1'b1, ir_pd);
        chk("lower pins", 4'hd, {ir_pd, vcut, u_shdn_n, u_sel_n});
        pins(8'h01, 1'b0);
        waitn(HOLD + 6);
        rdchk("periph", 5'h10, 32'h01);
        rdchk("lower", 5'h08, 32'h0d);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hff : 8'(xs());
            rx <= 1'(xs() >> 8);
            waitn(4);
            wr(5'h10, v);
            wr(5'h08, {4'h0, v[3:0]});
            @(negedge core_clk);
            pins(v, sup(v, rx));
            chk("ir_pd", v[3], ir_pd);
            chk("lower pins", v[3:0], {ir_pd, vcut, u_shdn_n, u_sel_n});
            rdchk("periph", 5'h10, {24'h0, v & 8'hf7});
            rdchk("lower", 5'h08, {28'h0, v[3:0]});
        end
        iokia_host_model_i.display_init();
        @(negedge core_clk);
        chk("display ready", 2'b10, {d_rst_n, d_sel_n});
        wr(5'h00, 8'h00);
        wr(5'h1c, 8'hff);
        rdchk("unmapped", 5'h1c, 32'h0);
        for (int i = 0; i < 7; i++) begin
            keys_n <= pats[i];
            waitn(4);
            @(negedge core_clk);
            chk("irq", pats[i] != 5'h1f, irq);
            chk("allkeys", pats[i] == 5'h00, akr);
            rdchk("keys", 5'h00, {24'h0, 3'h7, pats[i]});
        end
        keys_n <= 5'h1b;
        iokia_host_model_i.read_keys(rd);
        chk("isr keys", 32'hfb, rd);
        rx <= 1'b0;
        wr(5'h10, 8'h70);
        up <= 1'b0;
        waitn(4);
        @(negedge core_clk);
        chk("light off", 1'b0, light);
        chk("vibe off", 1'b0, vibe);
        @(posedge core_clk);
        up <= 1'b1;
        waitn(HOLD + 2);
        @(negedge core_clk);
        chk("light hold", 1'b0, light);
        chk("vibe hold", 1'b0, vibe);
        waitn(2);
        @(negedge core_clk);
        chk("light back", 1'b1, light);
        chk("vibe back", 1'b1, vibe);
        rdchk("status", 5'h18, 32'h0d);
        rx <= 1'b1;
        wr(5'h10, 8'hf0);
        waitn(4);
        chk("load override", 1'b1, vibe);
        bz_p <= 1'b1;
        bz_n <= 1'b1;
        waitn(4);
        chk("buzz", 1'b1, bo_p);
        chk("buzz neg", 1'b1, bo_n);
        lbat_n <= 1'b0;
        @(negedge core_clk);
        pins(8'h01, 1'b0);
        chk("ir_pd lbat", 1'b1, ir_pd);
        chk("lower pins lbat", 4'hd, {ir_pd, vcut, u_shdn_n, u_sel_n});
        chk("buzz lbat", 2'b00, {bo_p, bo_n});
        @(posedge core_clk);
        lbat_n <= 1'b1;
        waitn(4);
        rdchk("periph lbat", 5'h10, 32'h01);
        end_sim();
    end
    initial begin
        waitn(20000);
        err_total++;
        end_sim();
    end
endmodule

// [iokia_glue.sv]
// Purpose: Latched output ports, key interrupt and all-keys reset, alarm gating
// Assumes: Pins arrive asynchronously; one clock domain
// Notes:   Low-battery reset loads the output port defaults (lower 4'hd, peripheral 8'h01) asynchronously
//
// Register access over Avalon-MM was chosen for this implementation.

// Operation
// - Lower port bit 3 drives infrared power-down, default high; bits 4-7 unused.
// - Peripheral port bit 0 drives display chip select, active low, default high.
// - Peripheral port bit 1 drives display reset, active low, default low.
// - Peripheral port bit 2 enables display clock loop-back, default low; bit 3 unused.
// - Peripheral port bit 4 selects quiet mode; suppresses backlight and vibrator during reception.
// - Peripheral port bit 5 enables backlight, default low, subject to quiet gating.
// - Peripheral port bit 6 enables vibrator, default low, with quiet gating.
// - Peripheral port bit 7 turns on test load and overrides quiet mode.
// - Quiet mode: vibrator drops at up-converter shutdown, returns after delay.
// - Low-battery reset forces output ports to defaults, removing load, vibrator, backlight.
// - Keyboard interrupt raised whenever any of five keys is pressed.
// - All-keys reset raised only when all five keys are pressed.
// - Key port bits 0-4 return down, up, select, action, hidden; low pressed.
// - Buzzer drive signals are gated off by the low-battery reset.
// - Quiet mode: backlight drops at up-converter shutdown, returns after delay.
// - Output port bits held in resettable flip-flops loaded on port write.
// - Output ports set to their reset defaults whenever the low-battery reset is asserted.
module iokia_glue #(
    parameter int unsigned RESTART_CYCLES = iokia_pkg::RESTART_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        low_battery_reset_n,
    input  wire logic        down_button_n,
    input  wire logic        up_button_n,
    input  wire logic        select_button_n,
    input  wire logic        action_button_n,
    input  wire logic        hidden_button_n,
    input  wire logic        radio_rx_active,
    input  wire logic        upconverter_on,
    input  wire logic        buzzer_drive_pos,
    input  wire logic        buzzer_drive_neg,
    output logic             buzzer_out_pos,
    output logic             buzzer_out_neg,
    output logic             uart_select_n,
    output logic             uart_shutdown_n,
    output logic             vcc_cut,
    output logic             infrared_power_down,
    output logic             display_select_n,
    output logic             display_reset_n,
    output logic             display_clock_loopback_en,
    output logic             backlight_en,
    output logic             vibe_motor_en,
    output logic             test_load_en,
    output logic             keypad_irq,
    output logic             all_keys_reset
);

    // Pin synchronisers
    logic [8:0] pin_raw;
    logic [8:0] pin_meta_q;
    logic [8:0] pin_sync_q;
    logic [4:0] keys_s;
    logic       rx_s;
    logic       upconv_s;
    logic       buzz_pos_s;
    logic       buzz_neg_s;
    logic       lbat_meta_q;
    logic       lbat_sync_q;

    assign pin_raw = {buzzer_drive_neg, buzzer_drive_pos, upconverter_on, radio_rx_active,
                      hidden_button_n, action_button_n, select_button_n, up_button_n, down_button_n};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q  <= 9'h01f;
            pin_sync_q  <= 9'h01f;
            lbat_meta_q <= 1'b0;
            lbat_sync_q <= 1'b0;
        end else begin
            pin_meta_q  <= pin_raw;
            pin_sync_q  <= pin_meta_q;
            lbat_meta_q <= low_battery_reset_n;
            lbat_sync_q <= lbat_meta_q;
        end
    end

    assign keys_s     = pin_sync_q[4:0];
    assign rx_s       = pin_sync_q[5];
    assign upconv_s   = pin_sync_q[6];
    assign buzz_pos_s = pin_sync_q[7];
    assign buzz_neg_s = pin_sync_q[8];

    // Port reset: asserts at once on low battery, releases synchronously
    logic       port_arst_n;
    logic [1:0] port_rst_q;
    logic       port_rst_n;

    assign port_arst_n = rst_n & low_battery_reset_n;

    always_ff @(posedge core_clk or negedge port_arst_n) begin
        if (!port_arst_n) begin
            port_rst_q <= 2'h0;
        end else begin
            port_rst_q <= {port_rst_q[0], 1'b1};
        end
    end

    assign port_rst_n = port_rst_q[1];

    // Avalon slave: one wait cycle, answer on the second edge
    logic       ack_q;
    logic       req;
    logic [2:0] idx;
    logic       wr_lane0;

    assign req             = avs_read | avs_write;
    assign idx             = avs_address[4:2];
    assign avs_waitrequest = req & ~ack_q;
    assign wr_lane0        = avs_write & ~avs_waitrequest & avs_byteenable[0] & (avs_address[1:0] == 2'h0);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Output port flip-flops
    logic [3:0] lower_q;
    logic [7:0] periph_q;

    always_ff @(posedge core_clk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            lower_q  <= iokia_pkg::LOWER_RST;
            periph_q <= iokia_pkg::PERIPH_RST;
        end else if (wr_lane0) begin
            if (idx == iokia_pkg::REG_LOWER_IDX) begin
                lower_q <= avs_writedata[3:0];
            end
            if (idx == iokia_pkg::REG_PERIPH_IDX) begin
                periph_q <= avs_writedata[7:0] & iokia_pkg::PERIPH_MASK;
            end
        end
    end

    assign uart_select_n             = lower_q[iokia_pkg::LOW_UART_CS_BIT];
    assign uart_shutdown_n           = lower_q[iokia_pkg::LOW_UART_SHDN_BIT];
    assign vcc_cut                   = lower_q[iokia_pkg::LOW_CUT_VCC_BIT];
    assign infrared_power_down       = lower_q[iokia_pkg::LOW_IR_PD_BIT];
    assign display_select_n          = periph_q[iokia_pkg::PER_SEL_BIT];
    assign display_reset_n           = periph_q[iokia_pkg::PER_RST_BIT];
    assign display_clock_loopback_en = periph_q[iokia_pkg::PER_LOOP_BIT];
    assign test_load_en              = periph_q[iokia_pkg::PER_LOAD_BIT];

    // Up-converter restart hold-off
    logic [iokia_pkg::RESTART_W-1:0] hold_cnt_q;
    logic                            upconv_ok_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_q  <= '0;
            upconv_ok_q <= 1'b0;
        end else if (!upconv_s) begin
            hold_cnt_q  <= '0;
            upconv_ok_q <= 1'b0;
        end else if (!upconv_ok_q) begin
            if (hold_cnt_q == iokia_pkg::RESTART_W'(RESTART_CYCLES - 1)) begin
                upconv_ok_q <= 1'b1;
            end else begin
                hold_cnt_q <= hold_cnt_q + 1'b1;
            end
        end
    end

    // Quiet-mode gating of the high-power alarm loads
    logic quiet_eff;
    logic suppress;

    assign quiet_eff = periph_q[iokia_pkg::PER_QUIET_BIT] & ~periph_q[iokia_pkg::PER_LOAD_BIT];
    assign suppress  = quiet_eff & (rx_s | ~upconv_s | ~upconv_ok_q);

    always_ff @(posedge core_clk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            backlight_en  <= 1'b0;
            vibe_motor_en <= 1'b0;
        end else begin
            backlight_en  <= periph_q[iokia_pkg::PER_LIGHT_BIT] & ~suppress;
            vibe_motor_en <= periph_q[iokia_pkg::PER_VIBE_BIT] & ~suppress;
        end
    end

    // Buzzer pass-through, silenced on low battery
    always_ff @(posedge core_clk or negedge port_rst_n) begin
        if (!port_rst_n) begin
            buzzer_out_pos <= 1'b0;
            buzzer_out_neg <= 1'b0;
        end else begin
            buzzer_out_pos <= buzz_pos_s;
            buzzer_out_neg <= buzz_neg_s;
        end
    end

    // Key interrupt and all-keys reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            keypad_irq     <= 1'b0;
            all_keys_reset <= 1'b0;
        end else begin
            keypad_irq     <= (keys_s != iokia_pkg::KEYS_IDLE);
            all_keys_reset <= (keys_s == 5'h00);
        end
    end

    // Read data, latched on the edge that raises the acknowledge
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            iokia_pkg::REG_KEY_IDX: begin
                rd_byte[4:0]                     = keys_s;
                rd_byte[iokia_pkg::KEY_VCC_BIT]  = 1'b1;
                rd_byte[iokia_pkg::KEY_LBAT_BIT] = lbat_sync_q;
                rd_byte[iokia_pkg::KEY_LVCC_BIT] = 1'b1;
            end
            iokia_pkg::REG_LOWER_IDX: begin
                rd_byte[3:0] = lower_q;
            end
            iokia_pkg::REG_PERIPH_IDX: begin
                rd_byte = periph_q;
            end
            iokia_pkg::REG_STATUS_IDX: begin
                rd_byte = {3'h0, suppress, upconv_ok_q, upconv_s, rx_s, quiet_eff};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_read_key;
        avs_read && idx == iokia_pkg::REG_KEY_IDX && !ack_q;
    endsequence

    sequence s_read_done;
        avs_read && !avs_waitrequest;
    endsequence

    sequence s_restart;
        $rose(upconv_s) && quiet_eff && port_rst_n;
    endsequence

    AST_IRQ_ANY: assert property ((keys_s != iokia_pkg::KEYS_IDLE) |=> keypad_irq)
        else $error("keypad interrupt missing for a pressed key");

    AST_IRQ_IDLE: assert property ((keys_s == iokia_pkg::KEYS_IDLE) |=> !keypad_irq && !all_keys_reset)
        else $error("key outputs active with no key pressed");

    AST_ALL_KEYS: assert property ((keys_s != 5'h00) |=> !all_keys_reset)
        else $error("all-keys reset without all keys pressed");

    AST_ALL_KEYS_SET: assert property ((keys_s == 5'h00) |=> all_keys_reset)
        else $error("all-keys reset missing");

    AST_KEY_READ: assert property (s_read_key ##1 s_read_done |-> avs_readdata[4:0] == $past(keys_s))
        else $error("key port read returned wrong states");

    AST_PORT_WRITE: assert property (
        wr_lane0 && idx == iokia_pkg::REG_PERIPH_IDX && port_rst_n ##1 port_rst_n
        |-> display_select_n == $past(avs_writedata[0]) && display_reset_n == $past(avs_writedata[1]))
        else $error("peripheral port write not latched");

    AST_LOWBAT_CLEAR: assert property (!port_rst_n |-> !test_load_en && !vibe_motor_en && !backlight_en
        && display_select_n && infrared_power_down && !buzzer_out_pos && !buzzer_out_neg)
        else $error("outputs not at defaults under low-battery reset");

    AST_VIBE_DROP: assert property (quiet_eff && !upconv_s && port_rst_n ##1 port_rst_n |-> !vibe_motor_en)
        else $error("vibrator not dropped at up-converter shutdown");

    AST_LIGHT_HOLD: assert property (s_restart ##1 quiet_eff [*8] |-> !backlight_en)
        else $error("backlight re-enabled too early after restart");

    AST_LOAD_OVERRIDE: assert property (
        test_load_en && periph_q[iokia_pkg::PER_LIGHT_BIT] && port_rst_n ##1 port_rst_n |-> backlight_en)
        else $error("test load did not override quiet mode");

    AST_BUZZ_PASS: assert property (port_rst_n && buzz_pos_s ##1 port_rst_n |-> buzzer_out_pos)
        else $error("buzzer drive not passed through");

    AST_WAIT_ONE: assert property ($rose(req) && !ack_q |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not on the second edge");

endmodule

// [iokia_host_model.sv]
// Purpose: Processor model issuing Avalon-MM port accesses
// Assumes: One wait cycle or more, signalled by waitrequest
// Notes:   Requests change only by NBA right after a rising edge
module iokia_host_model (
    input  wire logic        core_clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        keypad_irq,
    output logic [4:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [3:0]       avs_byteenable,
    output logic [31:0]      avs_writedata
);
    timeunit 1ns;
    timeprecision 1ns;
    int to_cnt;
    initial begin
        to_cnt = 0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hf;
        avs_writedata = 32'h0;
    end
    // Held until waitrequest is seen low at an edge
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] rd);
        int n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) to_cnt++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Command stream may start only with the controller selected and out of reset
    task automatic display_init();
        logic [31:0] rd;
        access(1'b1, 5'h10, 8'h02, rd);
    endtask
    // Interrupt service: find the pressed keys
    task automatic read_keys(output logic [31:0] rd);
        int n = 0;
        while (keypad_irq !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (keypad_irq !== 1'b1) to_cnt++;
        access(1'b0, 5'h00, 8'h00, rd);
    endtask
endmodule

// [iokia_pkg.sv]
// Purpose: Shared constants for the port, key and alarm gating glue
// Assumes: 20 MHz core clock, Avalon-MM register access
// Notes:   Register byte address is four times the register index
package iokia_pkg;
    localparam int unsigned ADDR_W           = 5;
    localparam int unsigned IDX_W            = 3;
    localparam logic [2:0]  REG_KEY_IDX      = 3'h0;
    localparam logic [2:0]  REG_LOWER_IDX    = 3'h2;
    localparam logic [2:0]  REG_PERIPH_IDX   = 3'h4;
    localparam logic [2:0]  REG_STATUS_IDX   = 3'h6;

    // Lower output port, electrical levels
    localparam int unsigned LOW_UART_CS_BIT   = 0;
    localparam int unsigned LOW_UART_SHDN_BIT = 1;
    localparam int unsigned LOW_CUT_VCC_BIT   = 2;
    localparam int unsigned LOW_IR_PD_BIT     = 3;
    localparam logic [3:0]  LOWER_RST         = 4'hd;

    // Peripheral control port
    localparam int unsigned PER_SEL_BIT   = 0;
    localparam int unsigned PER_RST_BIT   = 1;
    localparam int unsigned PER_LOOP_BIT  = 2;
    localparam int unsigned PER_QUIET_BIT = 4;
    localparam int unsigned PER_LIGHT_BIT = 5;
    localparam int unsigned PER_VIBE_BIT  = 6;
    localparam int unsigned PER_LOAD_BIT  = 7;
    localparam logic [7:0]  PERIPH_RST    = 8'h01;
    localparam logic [7:0]  PERIPH_MASK   = 8'hf7;

    // Key input port
    localparam int unsigned KEY_N        = 5;
    localparam logic [4:0]  KEYS_IDLE    = 5'h1f;
    localparam int unsigned KEY_VCC_BIT  = 5;
    localparam int unsigned KEY_LBAT_BIT = 6;
    localparam int unsigned KEY_LVCC_BIT = 7;

    // Up-converter restart hold-off
    localparam int unsigned CLK_MHZ          = 20;
    localparam int unsigned RESTART_DELAY_US = 100;
    localparam int unsigned RESTART_CYCLES   = RESTART_DELAY_US * CLK_MHZ;
    localparam int unsigned RESTART_W        = 12;
endpackage
